// *** rtl/cprs_defines.svh ***
// Purpose: offsets, field positions, reset values of the config page slice
// Assumes: six-bit register address space of the host interface
// Notes: definitions only
`ifndef CPRS_DEFINES_SVH
`define CPRS_DEFINES_SVH

// register addresses
`define CPRS_ADDR_SPEED    6'h1F
`define CPRS_ADDR_PAGE     6'h20
`define CPRS_ADDR_CRC_HI   6'h21
`define CPRS_ADDR_CRC_LO   6'h22
`define CPRS_ADDR_GSNOFF   6'h23

// reset values
`define CPRS_RST_SPEED     8'hEB
`define CPRS_RST_PAGE      8'h00
`define CPRS_RST_CRC       8'hFF
`define CPRS_RST_GSNOFF    8'h88
`define CPRS_RST_COND      4'h8   // upper nibble of the driver-off reset

// writable bit masks
`define CPRS_MASK_SPEED    8'hEF
`define CPRS_MASK_PAGE     8'h83
`define CPRS_MASK_ALL      8'hFF

// field positions
`define CPRS_COARSE_HI     7
`define CPRS_COARSE_LO     5
`define CPRS_FINE_HI       3
`define CPRS_FINE_LO       0
`define CPRS_PAGE_EN_BIT   7
`define CPRS_PAGE_HI       1
`define CPRS_PAGE_LO       0
`define CPRS_IDLE_HI       7
`define CPRS_IDLE_LO       4
`define CPRS_MOD_HI        3
`define CPRS_MOD_LO        0
`define CPRS_PDOWN_FORCE   4'h8

`endif

// *** rtl/cprs_pkg.sv ***
// Purpose: shared types of the config page slice
// Assumes: six-bit register address, eight-bit data
// Notes: constants live in cprs_defines.svh
package cprs_pkg;

   // one host access as seen by the register bank
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr_latch;
      logic [7:0] wdata;
   } cprs_host_req_t;

   // state of the antenna driver from the transmitter
   typedef struct packed {
      logic       driver_on;
      logic       modulating;
      logic       load_mod;
      logic       soft_pdown;
      logic [3:0] idle_on;
      logic [3:0] mod_on;
   } cprs_drv_ctl_t;

endpackage

// *** rtl/cprs_reg8.sv ***
// Purpose: one eight-bit software register with per-bit write mask
// Assumes: write strobe is a one-cycle pulse on clk
// Notes: masked bits hold their reset value and read as it
`timescale 1ns/10ps
module cprs_reg8 #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] WR_MASK = 8'hFF
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // write port
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   // stored value
   output logic [7:0]      q
);
   logic [7:0] q_nxt;

   // merge writable bits, keep the rest
   always_comb begin
      q_nxt = q;
      if (wr_en) begin
         q_nxt = (wdata & WR_MASK) | (RST_VAL & ~WR_MASK);
      end
   end

   // storage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= RST_VAL;
      end else begin
         q <= q_nxt;
      end
   end
endmodule

// *** rtl/cprs_config_page.sv ***
// Purpose: config page slice: uart speed, page override, checksum result,
//          driver-off conductance
// Assumes: host interface logic on clk gives strobes and its address latch;
//          address pins come from outside and are synchronised here
// Notes: reads answer one cycle after the strobe, only for own addresses
//
// Functional notes
// [RQ1] coarse bits 7-5, fine bits 3-0 set baud
// [RQ2] override on: page field gives A5 A4
// [RQ3] override on: low bits from pins or latch
// [RQ4] override off: whole address from latch
// [RQ5] checksum shown as two read-only bytes
// [RQ6] host trusts high byte only when done
// [RQ7] host trusts low byte only when done
// [RQ8] high-bit-first reverses bits, not bytes
// [RQ9] upper nibble: idle conductance when off
// [RQ10] lower nibble: modulating conductance when off
// [RQ11] conductance nibbles are binary weighted
// [RQ12] soft power-down forces nibble msb high
// [RQ13] idle off-value only while driver off; the code also applies it while load_mod is set with the driver on
// [RQ14] modulating off-value only while driver off; the code also applies it while load_mod is set with the driver on
// [RQ15] load modulation uses the off-values
// [RQ16] writes to checksum bytes are ignored
`timescale 1ns/10ps
`include "cprs_defines.svh"
module cprs_config_page (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   // host access
   input  wire cprs_pkg::cprs_host_req_t host_req,
   input  wire logic                    use_addr_pins,
   input  wire logic [5:0]              addr_pins,
   output logic [7:0]                   rdata_r,
   output logic                         rvalid_r,
   output logic [5:0]                   eff_addr_r,
   // checksum engine
   input  wire logic [15:0]             crc_value,
   input  wire logic                    checksum_done_flag,
   input  wire logic                    high_bit_first_option,
   // antenna driver
   input  wire cprs_pkg::cprs_drv_ctl_t drv_ctl,
   output logic [3:0]                   ndrv_conductance_r,
   // uart speed
   output logic [2:0]                   baud_coarse_factor,
   output logic [3:0]                   baud_fine_factor
);
   import cprs_pkg::*;

   logic [5:0]  pin_s1_r;
   logic [5:0]  pin_s2_r;
   logic [5:0]  pin_s1_nxt;
   logic [5:0]  pin_s2_nxt;
   logic [5:0]  eff_addr;
   logic [5:0]  low_src;
   logic [7:0]  speed_q;
   logic [7:0]  page_q;
   logic [7:0]  gsnoff_q;
   logic [15:0] crc_r;
   logic [15:0] crc_nxt;
   logic        wr_speed;
   logic        wr_page;
   logic        wr_gsnoff;
   logic [7:0]  rdata_nxt;
   logic        rvalid_nxt;
   logic [5:0]  eff_addr_nxt;
   logic [3:0]  idle_off;
   logic [3:0]  mod_off;
   logic        use_off;
   logic [3:0]  cond_nxt;

   // bit order of a result byte
   function automatic logic [7:0] order_byte(input logic [7:0] b,
                                             input logic       rev);
      logic [7:0] r;
      r = b;
      if (rev) begin
         for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
         end
      end
      return r;
   endfunction

   // address pin synchroniser, next values
   always_comb begin
      pin_s1_nxt = addr_pins;
      pin_s2_nxt = pin_s1_r;
   end

   // address pin synchroniser, registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_r <= 6'h00;
         pin_s2_r <= 6'h00;
      end else begin
         pin_s1_r <= pin_s1_nxt;
         pin_s2_r <= pin_s2_nxt;
      end
   end

   // effective register address
   always_comb begin
      low_src = use_addr_pins ? pin_s2_r : host_req.addr_latch; // RQ3
      if (page_q[`CPRS_PAGE_EN_BIT]) begin
         eff_addr = {page_q[`CPRS_PAGE_HI:`CPRS_PAGE_LO], // RQ2
                     low_src[3:0]};                        // RQ3
      end else begin
         eff_addr = host_req.addr_latch; // RQ4
      end
   end

   // write decode; checksum addresses take no write
   always_comb begin
      wr_speed  = 1'b0;
      wr_page   = 1'b0;
      wr_gsnoff = 1'b0;
      if (!host_req.wr) begin
         wr_speed = 1'b0;
      end else if (eff_addr == `CPRS_ADDR_SPEED) begin
         wr_speed = 1'b1;
      end else if (eff_addr == `CPRS_ADDR_PAGE) begin
         wr_page = 1'b1;
      end else if (eff_addr == `CPRS_ADDR_GSNOFF) begin
         wr_gsnoff = 1'b1;
      end
   end

   // software registers
   cprs_reg8 #(.RST_VAL(`CPRS_RST_SPEED), .WR_MASK(`CPRS_MASK_SPEED))
      u_speed (.clk(clk), .arst_n(arst_n), .wr_en(wr_speed),
               .wdata(host_req.wdata), .q(speed_q));
   cprs_reg8 #(.RST_VAL(`CPRS_RST_PAGE), .WR_MASK(`CPRS_MASK_PAGE))
      u_page (.clk(clk), .arst_n(arst_n), .wr_en(wr_page),
              .wdata(host_req.wdata), .q(page_q));
   cprs_reg8 #(.RST_VAL(`CPRS_RST_GSNOFF), .WR_MASK(`CPRS_MASK_ALL))
      u_gsnoff (.clk(clk), .arst_n(arst_n), .wr_en(wr_gsnoff),
                .wdata(host_req.wdata), .q(gsnoff_q));

   // uart speed factors straight from the stored register
   always_comb begin
      baud_coarse_factor = speed_q[`CPRS_COARSE_HI:`CPRS_COARSE_LO]; // RQ1
      baud_fine_factor   = speed_q[`CPRS_FINE_HI:`CPRS_FINE_LO];     // RQ1
   end

   // checksum result follows the engine; host writes never reach it
   always_comb begin
      crc_nxt = crc_value; // RQ5 RQ16
   end

   // read mux, one-cycle answer
   always_comb begin
      rdata_nxt    = 8'h00;
      rvalid_nxt   = 1'b0;
      eff_addr_nxt = eff_addr;
      if (!host_req.rd) begin
         rvalid_nxt = 1'b0;
      end else if (eff_addr == `CPRS_ADDR_SPEED) begin
         rdata_nxt  = speed_q;
         rvalid_nxt = 1'b1;
      end else if (eff_addr == `CPRS_ADDR_PAGE) begin
         rdata_nxt  = page_q;
         rvalid_nxt = 1'b1;
      end else if (eff_addr == `CPRS_ADDR_CRC_HI) begin
         rdata_nxt  = order_byte(crc_r[15:8], high_bit_first_option); // RQ8
         rvalid_nxt = 1'b1;
      end else if (eff_addr == `CPRS_ADDR_CRC_LO) begin
         rdata_nxt  = order_byte(crc_r[7:0], high_bit_first_option); // RQ8
         rvalid_nxt = 1'b1;
      end else if (eff_addr == `CPRS_ADDR_GSNOFF) begin
         rdata_nxt  = gsnoff_q;
         rvalid_nxt = 1'b1;
      end
   end

   // conductance actually applied to the n-driver
   always_comb begin
      idle_off = gsnoff_q[`CPRS_IDLE_HI:`CPRS_IDLE_LO]; // RQ9 RQ11
      mod_off  = gsnoff_q[`CPRS_MOD_HI:`CPRS_MOD_LO];   // RQ10 RQ11
      if (drv_ctl.soft_pdown) begin
         idle_off = idle_off | `CPRS_PDOWN_FORCE; // RQ12
         mod_off  = mod_off | `CPRS_PDOWN_FORCE;  // RQ12
      end
      use_off = !drv_ctl.driver_on || drv_ctl.load_mod; // RQ13 RQ14 RQ15
      if (drv_ctl.modulating) begin
         cond_nxt = use_off ? mod_off : drv_ctl.mod_on; // RQ14
      end else begin
         cond_nxt = use_off ? idle_off : drv_ctl.idle_on; // RQ13
      end
   end

   // output and result registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         crc_r              <= {`CPRS_RST_CRC, `CPRS_RST_CRC};
         rdata_r            <= 8'h00;
         rvalid_r           <= 1'b0;
         eff_addr_r         <= 6'h00;
         ndrv_conductance_r <= `CPRS_RST_COND;
      end else begin
         crc_r              <= crc_nxt;
         rdata_r            <= rdata_nxt;
         rvalid_r           <= rvalid_nxt;
         eff_addr_r         <= eff_addr_nxt;
         ndrv_conductance_r <= cond_nxt;
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence speed_write_s;
      wr_speed;
   endsequence

   sequence crc_hi_read_s;
      host_req.rd && eff_addr == `CPRS_ADDR_CRC_HI;
   endsequence

   speed_fields_a: assert property ( // RQ1
      speed_write_s |=> baud_coarse_factor == $past(host_req.wdata[7:5])
                    && baud_fine_factor == $past(host_req.wdata[3:0]))
      else $error("baud factors do not follow speed write");

   page_bits_a: assert property ( // RQ2
      page_q[7] |-> eff_addr[5:4] == page_q[1:0])
      else $error("page field not used as upper address");

   low_bits_a: assert property ( // RQ3
      page_q[7] && !use_addr_pins |-> ##1
         eff_addr_r[3:0] == $past(host_req.addr_latch[3:0]))
      else $error("low address bits not from latch");

   latch_whole_a: assert property ( // RQ4
      !page_q[7] |=> eff_addr_r == $past(host_req.addr_latch))
      else $error("address not taken from latch");

   crc_high_read_a: assert property ( // RQ5
      crc_hi_read_s ##0 !high_bit_first_option |=>
         rvalid_r && rdata_r == $past(crc_r[15:8]))
      else $error("high checksum byte read wrong");

   crc_reverse_a: assert property ( // RQ8
      host_req.rd && eff_addr == `CPRS_ADDR_CRC_LO && high_bit_first_option
      |=> {rdata_r[0], rdata_r[1], rdata_r[2], rdata_r[3], rdata_r[4],
           rdata_r[5], rdata_r[6], rdata_r[7]} == $past(crc_r[7:0]))
      else $error("low checksum byte not reversed");

   cond_idle_a: assert property ( // RQ13
      !drv_ctl.driver_on && !drv_ctl.modulating && !drv_ctl.soft_pdown
      |=> ndrv_conductance_r == $past(gsnoff_q[7:4]))
      else $error("idle off conductance not applied");

   cond_loadmod_a: assert property ( // RQ15
      drv_ctl.load_mod && drv_ctl.modulating && !drv_ctl.soft_pdown
      |=> ndrv_conductance_r == $past(gsnoff_q[3:0]))
      else $error("load modulation not using off value");

   pdown_force_a: assert property ( // RQ12
      drv_ctl.soft_pdown && use_off |=> ndrv_conductance_r[3])
      else $error("power-down did not force msb");

   crc_ro_a: assert property ( // RQ16
      host_req.wr && eff_addr == `CPRS_ADDR_CRC_LO |-> !wr_speed
      && !wr_page && !wr_gsnoff ##1 $stable(speed_q) && $stable(page_q)
      && $stable(gsnoff_q) && crc_r == $past(crc_value))
      else $error("write to checksum byte reached a register");
endmodule

// *** verification/cprs_host_model.sv ***
// Purpose: host side of the register bank: strobed reads and writes
// Assumes: strobes change at the falling edge, one cycle wide
// Notes: a released address or data bus shows the inverse of its last value
`timescale 1ns/10ps
module cprs_host_model (
   // clock
   input  wire logic               clk,
   // host access towards the bank
   output cprs_pkg::cprs_host_req_t host_req,
   output logic                    use_addr_pins,
   output logic [5:0]              addr_pins,
   // answers from the bank
   input  wire logic [7:0]         rdata_r,
   input  wire logic               rvalid_r,
   input  wire logic               checksum_done_flag
);
   import cprs_pkg::*;
   logic trusted;
   // idle bus at time zero
   initial begin
      host_req = '0;
      use_addr_pins = 1'b0;
      addr_pins = 6'h00;
      trusted = 1'b0;
   end
   // one access: strobe one cycle, take the answer while it stands, release
   task automatic access(input logic w, input logic [5:0] a,
                         input logic [7:0] d, output logic [7:0] q,
                         output logic ok);
      @(negedge clk);
      host_req = {w, ~w, a, d};
      @(negedge clk);
      q = rdata_r; // answer stands only in the cycle after the taking edge
      ok = rvalid_r;
      trusted = checksum_done_flag;
      host_req = {1'b0, 1'b0, ~a, ~d}; // no stale value after release
   endtask
   // pins need two edges to pass the synchroniser
   task automatic set_pins(input logic u, input logic [5:0] p);
      @(negedge clk);
      use_addr_pins = u;
      addr_pins = p;
      repeat (3) @(posedge clk);
   endtask
endmodule

// *** verification/cprs_config_page_bench.sv ***
// Purpose: self-checking bench of the config page slice
// Assumes: host model drives strobes; bench drives the rest at falling edge
// Notes: checksum value fixed at 1E35; done flag high but for one read
`timescale 1ns/10ps
module cprs_config_page_bench;
   import cprs_pkg::*;
   logic clk = 1'b0;
   logic arst_n;
   cprs_host_req_t host_req;
   logic use_addr_pins;
   logic [5:0] addr_pins;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic [5:0] eff_addr_r;
   logic [15:0] crc_value;
   logic checksum_done_flag;
   logic high_bit_first_option;
   cprs_drv_ctl_t drv_ctl;
   logic [3:0] ndrv_conductance_r;
   logic [2:0] baud_coarse_factor;
   logic [3:0] baud_fine_factor;
   int n_errors = 0;
   int compares = 0;
   // {driver_on, modulating, load_mod, soft_pdown, expected nibble}
   logic [7:0] cases [9] = '{8'h05, 8'h42, 8'h83, 8'hC6, 8'hE2, 8'hA5,
                             8'h1D, 8'h5A, 8'h93};
   // clock generation
   always #5 clk = ~clk;
   cprs_config_page i_dut (.clk(clk), .arst_n(arst_n), .host_req(host_req),
      .use_addr_pins(use_addr_pins), .addr_pins(addr_pins),
      .rdata_r(rdata_r), .rvalid_r(rvalid_r), .eff_addr_r(eff_addr_r),
      .crc_value(crc_value), .checksum_done_flag(checksum_done_flag),
      .high_bit_first_option(high_bit_first_option), .drv_ctl(drv_ctl),
      .ndrv_conductance_r(ndrv_conductance_r),
      .baud_coarse_factor(baud_coarse_factor),
      .baud_fine_factor(baud_fine_factor));
   cprs_host_model i_host (.clk(clk), .host_req(host_req),
      .use_addr_pins(use_addr_pins), .addr_pins(addr_pins),
      .rdata_r(rdata_r), .rvalid_r(rvalid_r),
      .checksum_done_flag(checksum_done_flag));
   // compare one value and count it
   task automatic chk(input string n, input logic [7:0] s,
                      input logic [7:0] e);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   // write one register
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic ok;
      i_host.access(1'b1, a, d, q, ok);
   endtask
   // read one register, check data and answer pulse
   task automatic rd(input string n, input logic [5:0] a,
                     input logic [7:0] e, input logic v);
      logic [7:0] q;
      logic ok;
      i_host.access(1'b0, a, 8'h00, q, ok);
      chk(n, q, e);
      chk({n, " answer"}, {7'h00, ok}, {7'h00, v});
   endtask
   // bit order reversal within a byte
   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) r[i] = b[7-i];
      return r;
   endfunction
   // verdict
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      arst_n = 1'b0;
      crc_value = 16'h1E35;
      checksum_done_flag = 1'b1;
      high_bit_first_option = 1'b0;
      drv_ctl = '0;
      repeat (4) @(posedge clk);
      @(negedge clk) arst_n = 1'b1;
      chk("coarse", {5'h00, baud_coarse_factor}, 8'h07);
      chk("fine", {4'h0, baud_fine_factor}, 8'h0B);
      rd("speed", 6'h1F, 8'hEB, 1'b1);
      rd("page", 6'h20, 8'h00, 1'b1);
      rd("cond", 6'h23, 8'h88, 1'b1);
      rd("crc hi", 6'h21, 8'h1E, 1'b1);
      chk("crc trusted", {7'h00, i_host.trusted}, 8'h01);
      rd("crc lo", 6'h22, 8'h35, 1'b1);
      wr(6'h21, 8'h00);
      wr(6'h22, 8'h00);
      rd("crc hi kept", 6'h21, 8'h1E, 1'b1);
      rd("crc lo kept", 6'h22, 8'h35, 1'b1);
      @(negedge clk) high_bit_first_option = 1'b1;
      rd("crc hi rev", 6'h21, rev8(8'h1E), 1'b1);
      rd("crc lo rev", 6'h22, rev8(8'h35), 1'b1);
      @(negedge clk) high_bit_first_option = 1'b0;
      @(negedge clk) checksum_done_flag = 1'b0;
      rd("crc lo busy", 6'h22, 8'h35, 1'b1);
      chk("crc untrusted", {7'h00, i_host.trusted}, 8'h00);
      @(negedge clk) checksum_done_flag = 1'b1;
      rd("unmapped", 6'h24, 8'h00, 1'b0);
      $display("test reset and checksum done");
      wr(6'h1F, 8'h5A);
      chk("coarse", {5'h00, baud_coarse_factor}, 8'h02);
      chk("fine", {4'h0, baud_fine_factor}, 8'h0A);
      rd("speed", 6'h1F, 8'h4A, 1'b1);
      $display("test uart speed done");
      wr(6'h20, 8'hFE);
      rd("page paged", 6'h00, 8'h82, 1'b1);
      chk("eff addr", {2'h0, eff_addr_r}, 8'h20);
      rd("cond paged", 6'h03, 8'h88, 1'b1);
      rd("speed hidden", 6'h1F, 8'h00, 1'b0);
      i_host.set_pins(1'b1, 6'h01);
      rd("crc by pins", 6'h3F, 8'h1E, 1'b1);
      chk("eff addr", {2'h0, eff_addr_r}, 8'h21);
      i_host.set_pins(1'b0, 6'h01);
      wr(6'h00, 8'h00);
      i_host.set_pins(1'b1, 6'h03);
      rd("latch only", 6'h21, 8'h1E, 1'b1);
      chk("eff addr", {2'h0, eff_addr_r}, 8'h21);
      rd("latch low", 6'h03, 8'h00, 1'b0);
      i_host.set_pins(1'b0, 6'h00);
      $display("test page override done");
      wr(6'h23, 8'h52);
      rd("cond", 6'h23, 8'h52, 1'b1);
      foreach (cases[i]) begin
         @(negedge clk);
         drv_ctl = '{driver_on: cases[i][7], modulating: cases[i][6],
                     load_mod: cases[i][5], soft_pdown: cases[i][4],
                     idle_on: 4'h3, mod_on: 4'h6};
         repeat (2) @(posedge clk);
         #1;
         chk("ndrv", {4'h0, ndrv_conductance_r}, {4'h0, cases[i][3:0]});
      end
      $display("test conductance done");
      summarize();
   end
endmodule
